// ---- sepc_regs.svh ----
// constants of the serial eeprom command port: mode codes, bit counts, timing
// assumes inclusion by sepc_pkg, the design files and the bench
`ifndef SEPC_REGS_SVH
`define SEPC_REGS_SVH

// ----------------------------------------
// mode codes, first bit sent is the msb
// ----------------------------------------
`define SEPC_MODE_READ       8'ha8
`define SEPC_MODE_WRITE      8'ha4
`define SEPC_MODE_WEN        8'ha3
`define SEPC_MODE_WDS        8'ha0
`define SEPC_MODE_STAT       8'ha9

// ----------------------------------------
// frame positions, counted in rising edges
// ----------------------------------------
`define SEPC_MODE_LAST       6'h07
`define SEPC_ADDR_FIRST      6'h08
`define SEPC_ADDR_LAST       6'h0f
`define SEPC_DATA_FIRST      6'h10
`define SEPC_DATA_LAST       6'h1f
`define SEPC_CNT_MAX         6'h3f

// ----------------------------------------
// status flag select, {second bit, first bit}
// ----------------------------------------
`define SEPC_SEL_BUSY        2'h0
`define SEPC_SEL_WEN         2'h1
`define SEPC_SEL_ECC         2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define SEPC_CLK_PERIOD_NS   10
`define SEPC_WRITE_TIME_US   10000

`endif

// ---- sepc_pkg.sv ----
// types and shared helpers of the serial eeprom command port
// assumes sepc_regs.svh next to it
package sepc_pkg;
	`include "sepc_regs.svh"

	typedef enum logic [2:0] {SEPC_OP_NONE, SEPC_OP_READ, SEPC_OP_WRITE, SEPC_OP_WEN, SEPC_OP_WDS,
		SEPC_OP_STAT} sepc_op_t;

	typedef enum logic {SEPC_T_IDLE, SEPC_T_RUN} sepc_tstate_t;

	// after a write only a status mode is honoured
	function automatic sepc_op_t sepc_decode(input logic [7:0] code, input logic post_wr);
		sepc_op_t op;
		op = SEPC_OP_NONE;
		if (code == `SEPC_MODE_STAT) begin
			op = SEPC_OP_STAT;
		end else if (!post_wr) begin
			if (code == `SEPC_MODE_READ) op = SEPC_OP_READ;
			if (code == `SEPC_MODE_WRITE) op = SEPC_OP_WRITE;
			if (code == `SEPC_MODE_WEN) op = SEPC_OP_WEN;
			if (code == `SEPC_MODE_WDS) op = SEPC_OP_WDS;
		end
		return op;
	endfunction

	function automatic logic sepc_parity(input logic [7:0] b);
		return ^b;
	endfunction
endpackage

// ---- sepc_write_timer.sv ----
// self-timed write engine on the core clock
// assumes the request toggle, reset pin and power-good pin come from other domains
`timescale 1ns/10ps
module sepc_write_timer #(
	parameter int WRITE_CYC = 1000000
) (
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic wr_req_tgl,
	input  wire logic reset_pin,
	input  wire logic power_ok,
	output logic      rdy_busy,
	output logic      commit
);
	import sepc_pkg::*;

	logic         tgl_meta;
	logic         tgl_sync;
	logic         tgl_prev;
	logic         rst_meta;
	logic         rst_sync;
	logic         pwr_meta;
	logic         pwr_sync;
	logic [23:0]  tcnt;
	sepc_tstate_t state;
	sepc_tstate_t next_state;

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tgl_meta <= 1'b0;
			tgl_sync <= 1'b0;
			tgl_prev <= 1'b0;
			rst_meta <= 1'b1;
			rst_sync <= 1'b1;
			pwr_meta <= 1'b0;
			pwr_sync <= 1'b0;
		end else begin
			tgl_meta <= wr_req_tgl;
			tgl_sync <= tgl_meta;
			tgl_prev <= tgl_sync;
			rst_meta <= reset_pin;
			rst_sync <= rst_meta;
			pwr_meta <= power_ok;
			pwr_sync <= pwr_meta;
		end
	end

	// ----------------------------------------
	// timer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			SEPC_T_IDLE: begin
				if (tgl_sync != tgl_prev && pwr_sync && !rst_sync) next_state = SEPC_T_RUN;
			end
			SEPC_T_RUN: begin
				if (rst_sync || !pwr_sync) next_state = SEPC_T_IDLE;
				else if (tcnt == 24'(WRITE_CYC - 1)) next_state = SEPC_T_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) state <= SEPC_T_IDLE;
		else state <= next_state;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) tcnt <= 24'h000000;
		else if (state == SEPC_T_RUN) tcnt <= tcnt + 24'h000001;
		else tcnt <= 24'h000000;
	end

	// cs is never seen here, so the write runs on
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) commit <= 1'b0;
		else commit <= state == SEPC_T_RUN && next_state == SEPC_T_IDLE && !rst_sync && pwr_sync;
	end

	// busy low for the whole write
	// low while power is not good
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) rdy_busy <= 1'b0;
		else rdy_busy <= pwr_sync && next_state == SEPC_T_IDLE;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_start_busy;
		@(posedge core_clk) disable iff (!resetn)
		(state == SEPC_T_IDLE && next_state == SEPC_T_RUN) |=> !rdy_busy [*2];
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("busy not low at write start");

	property p_done_ready;
		@(posedge core_clk) disable iff (!resetn)
		commit |-> rdy_busy && $past(tcnt) == 24'(WRITE_CYC - 1);
	endproperty
	a_done_ready: assert property (p_done_ready) else $error("write end not timed or busy stuck");

	property p_abort;
		@(posedge core_clk) disable iff (!resetn)
		(state == SEPC_T_RUN && rst_sync) |=> state == SEPC_T_IDLE ##1 !commit;
	endproperty
	a_abort: assert property (p_abort) else $error("reset did not abort write");

	property p_power_busy;
		@(posedge core_clk) disable iff (!resetn)
		!pwr_sync |=> !rdy_busy && !commit;
	endproperty
	a_power_busy: assert property (p_power_busy) else $error("ready shown without power");
endmodule // sepc_write_timer

// ---- sepc_serial_eeprom.sv ----
// serial eeprom command port: 128 words of 16 bits behind a clocked serial link
// assumes sck idles low, cs and the reset pin are asynchronous pins,
// so_out and so_oe drive a pin that may be shared with serial_in
`timescale 1ns/10ps
`include "sepc_regs.svh"
module sepc_serial_eeprom #(
	parameter int WRITE_TIME_US = `SEPC_WRITE_TIME_US
) (
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic sck,
	input  wire logic cs,
	input  wire logic serial_in,
	input  wire logic reset_pin,
	input  wire logic power_ok,
	output logic      so_out,
	output logic      so_oe,
	output logic      rdy_busy
);
	import sepc_pkg::*;

	localparam int WRITE_CYC = (WRITE_TIME_US * 1000 + `SEPC_CLK_PERIOD_NS - 1) / `SEPC_CLK_PERIOD_NS;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	// two byte parity bits sit above the data word
	logic [17:0]  mem [0:127];

	logic         seq_rst_n;
	logic [5:0]   bit_cnt;
	sepc_op_t     op;
	logic         post_wr;
	logic [7:0]   mode_sh;
	logic [7:0]   addr_sh;
	logic [15:0]  data_sh;
	logic         we_state;
	logic [6:0]   wr_addr;
	logic [15:0]  wr_data;
	logic         wr_tgl;
	logic [6:0]   rd_addr;
	logic         ecc_flag;
	logic         ready_meta;
	logic         ready_sync;
	logic         commit;
	logic [17:0]  rd_word;
	logic         stat_bit;

	// ----------------------------------------
	// sequencer reset
	// ----------------------------------------
	// cs high holds the sequencer
	// reset pin clears it as well
	// inputs ignored while power is not good
	assign seq_rst_n = resetn & ~cs & ~reset_pin & power_ok;

	// ----------------------------------------
	// frame counter and mode, link clock
	// ----------------------------------------
	// frame position in rising edges
	always_ff @(posedge sck or negedge seq_rst_n) begin
		if (!seq_rst_n) begin
			bit_cnt <= 6'h00;
		end else if (bit_cnt == `SEPC_DATA_LAST && op == SEPC_OP_WRITE) begin
			bit_cnt <= 6'h00;
		end else if (bit_cnt != `SEPC_CNT_MAX) begin
			bit_cnt <= bit_cnt + 6'h01;
		end
	end

	// serial_in taken on the rising edge
	always_ff @(posedge sck or negedge seq_rst_n) begin
		if (!seq_rst_n) mode_sh <= 8'h00;
		else if (bit_cnt <= `SEPC_MODE_LAST) mode_sh <= {mode_sh[6:0], serial_in};
	end

	always_ff @(posedge sck or negedge seq_rst_n) begin
		if (!seq_rst_n) op <= SEPC_OP_NONE;
		else if (bit_cnt == `SEPC_MODE_LAST) op <= sepc_decode({mode_sh[6:0], serial_in}, post_wr);
	end

	// a new mode after a write is status only
	always_ff @(posedge sck or negedge seq_rst_n) begin
		if (!seq_rst_n) post_wr <= 1'b0;
		else if (bit_cnt == `SEPC_DATA_LAST && op == SEPC_OP_WRITE) post_wr <= 1'b1;
	end

	// a0 arrives first, bit 7 is the trailing zero
	always_ff @(posedge sck or negedge seq_rst_n) begin
		if (!seq_rst_n) addr_sh <= 8'h00;
		else if (bit_cnt >= `SEPC_ADDR_FIRST && bit_cnt <= `SEPC_ADDR_LAST) addr_sh[bit_cnt[2:0]] <= serial_in;
	end

	always_ff @(posedge sck or negedge seq_rst_n) begin
		if (!seq_rst_n) data_sh <= 16'h0000;
		else if (bit_cnt >= `SEPC_DATA_FIRST && bit_cnt <= `SEPC_DATA_LAST) data_sh[bit_cnt[3:0]] <= serial_in;
	end

	// ----------------------------------------
	// state kept across frames
	// ----------------------------------------
	// reset leaves writes disabled; the host enables first
	always_ff @(posedge sck or negedge resetn) begin
		if (!resetn) begin
			we_state <= 1'b0;
		end else if (bit_cnt == `SEPC_ADDR_LAST && op == SEPC_OP_WEN) begin
			we_state <= 1'b1;
		end else if (bit_cnt == `SEPC_ADDR_LAST && op == SEPC_OP_WDS) begin
			we_state <= 1'b0;
		end
	end

	// disabled or busy device raises no request
	// address and data stay put until the next write, long after the core reads them
	always_ff @(posedge sck or negedge resetn) begin
		if (!resetn) begin
			wr_addr <= 7'h00;
			wr_data <= 16'h0000;
			wr_tgl  <= 1'b0;
		end else if (bit_cnt == `SEPC_DATA_LAST && op == SEPC_OP_WRITE && we_state && ready_sync) begin
			wr_addr <= addr_sh[6:0];
			wr_data <= {serial_in, data_sh[14:0]};
			wr_tgl  <= ~wr_tgl;
		end
	end

	assign rd_word = mem[addr_sh[6:0]];

	// ecc flag follows the last addressed read word
	always_ff @(posedge sck or negedge resetn) begin
		if (!resetn) begin
			rd_addr  <= 7'h00;
			ecc_flag <= 1'b0;
		end else if (bit_cnt == `SEPC_ADDR_LAST && op == SEPC_OP_READ) begin
			rd_addr  <= addr_sh[6:0];
			ecc_flag <= (sepc_parity(rd_word[7:0]) != rd_word[16]) | (sepc_parity(rd_word[15:8]) != rd_word[17]);
		end
	end

	// busy level into the link domain for the status flag
	always_ff @(posedge sck or negedge resetn) begin
		if (!resetn) begin
			ready_meta <= 1'b0;
			ready_sync <= 1'b0;
		end else begin
			ready_meta <= rdy_busy;
			ready_sync <= ready_meta;
		end
	end

	// ----------------------------------------
	// serial output, falling edge
	// ----------------------------------------
	// flag chosen by the first two address bits
	always_comb begin
		unique case (addr_sh[1:0])
			`SEPC_SEL_BUSY: stat_bit = ready_sync;
			`SEPC_SEL_WEN:  stat_bit = ~we_state;
			`SEPC_SEL_ECC:  stat_bit = ecc_flag;
			default:        stat_bit = 1'b1;
		endcase
	end

	// output moves on the falling edge
	// first output bit at the sixteenth falling edge
	// pin released whenever nothing is presented
	always_ff @(negedge sck or negedge seq_rst_n) begin
		if (!seq_rst_n) begin
			so_out <= 1'b0;
			so_oe  <= 1'b0;
		end else if (bit_cnt >= `SEPC_DATA_FIRST && op == SEPC_OP_STAT) begin
			so_out <= stat_bit;
			so_oe  <= 1'b1;
		end else if (bit_cnt >= `SEPC_DATA_FIRST && bit_cnt <= `SEPC_DATA_LAST && op == SEPC_OP_READ) begin
			so_out <= mem[rd_addr][bit_cnt[3:0]];
			so_oe  <= 1'b1;
		end else begin
			so_out <= 1'b0;
			so_oe  <= 1'b0;
		end
	end

	// ----------------------------------------
	// write engine, core clock
	// ----------------------------------------
	// a tied cs and reset pin is seen as reset and aborts here
	sepc_write_timer #(
		.WRITE_CYC (WRITE_CYC)
	) u_timer (
		.core_clk   (core_clk),
		.resetn     (resetn),
		.wr_req_tgl (wr_tgl),
		.reset_pin  (reset_pin),
		.power_ok   (power_ok),
		.rdy_busy   (rdy_busy),
		.commit     (commit)
	);

	// the array changes only when the timer completes
	// wr_addr and wr_data are quiet for the whole write, so no resync is needed
	always_ff @(posedge core_clk) begin
		if (commit) mem[wr_addr] <= {sepc_parity(wr_data[15:8]), sepc_parity(wr_data[7:0]), wr_data};
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_decode_read;
		@(posedge sck) disable iff (!seq_rst_n)
		(bit_cnt == `SEPC_MODE_LAST && !post_wr && {mode_sh[6:0], serial_in} == `SEPC_MODE_READ)
			|=> op == SEPC_OP_READ;
	endproperty
	a_decode_read: assert property (p_decode_read) else $error("read code not decoded");

	property p_wen;
		@(posedge sck) disable iff (!seq_rst_n)
		(bit_cnt == `SEPC_ADDR_LAST && op == SEPC_OP_WEN) |=> we_state;
	endproperty
	a_wen: assert property (p_wen) else $error("enable mode did not enable");

	property p_wds;
		@(posedge sck) disable iff (!seq_rst_n)
		(bit_cnt == `SEPC_ADDR_LAST && op == SEPC_OP_WDS) |=> !we_state;
	endproperty
	a_wds: assert property (p_wds) else $error("disable mode did not disable");

	property p_no_write_disabled;
		@(posedge sck) disable iff (!seq_rst_n)
		(bit_cnt == `SEPC_DATA_LAST && op == SEPC_OP_WRITE && !we_state) |=> $stable(wr_tgl);
	endproperty
	a_no_write_disabled: assert property (p_no_write_disabled) else $error("write raised while disabled");

	property p_read_addr;
		@(posedge sck) disable iff (!seq_rst_n)
		(bit_cnt == `SEPC_ADDR_LAST && op == SEPC_OP_READ) |=> rd_addr == $past(addr_sh[6:0]);
	endproperty
	a_read_addr: assert property (p_read_addr) else $error("read address not taken");

	property p_status_out;
		@(posedge sck) disable iff (!seq_rst_n)
		(op == SEPC_OP_STAT && bit_cnt == 6'h11) |-> so_oe;
	endproperty
	a_status_out: assert property (p_status_out) else $error("status flag not presented");

	property p_release;
		@(posedge sck) disable iff (!seq_rst_n)
		(op == SEPC_OP_WRITE || op == SEPC_OP_WEN || op == SEPC_OP_WDS || bit_cnt < `SEPC_DATA_FIRST)
			|-> !so_oe;
	endproperty
	a_release: assert property (p_release) else $error("output driven without data");

	property p_post_write;
		@(posedge sck) disable iff (!seq_rst_n)
		(post_wr && bit_cnt == `SEPC_MODE_LAST && {mode_sh[6:0], serial_in} != `SEPC_MODE_STAT)
			|=> op == SEPC_OP_NONE;
	endproperty
	a_post_write: assert property (p_post_write) else $error("mode accepted after write");
endmodule // sepc_serial_eeprom

// ---- sepc_host.sv ----
// host model: drives cs, sck and serial_in, samples so_out
// assumes the bench calls frame() by hierarchy, one frame at a time
`timescale 1ns/10ps
module sepc_host (
	output logic      sck,
	output logic      cs,
	output logic      serial_in,
	input  wire logic so_out,
	input  wire logic so_oe
);
	initial begin
		sck = 1'b0;
		cs = 1'b1;
		serial_in = 1'b0;
	end

	// ----------------------------------------
	// frame
	// ----------------------------------------
	// mode msb first, a0 first, d0 first
	function automatic logic bit_of(input logic [7:0] m, input logic [7:0] a, input logic [15:0] d, input int k);
		if (k < 8) return m[7-k];
		if (k < 16) return a[k-8];
		return d[k-16];
	endfunction

	// sck stands still outside frames
	task automatic frame(input logic [7:0] m, input logic [7:0] a, input logic [15:0] d, input int n,
		output logic [15:0] rx, output logic oe);
		rx = 16'h0;
		oe = 1'b0;
		cs = 1'b0;
		#20;
		for (int k = 0; k < n; k++) begin
			// data settled before the rising edge
			serial_in = bit_of(m, a, d, k);
			#3 sck = 1'b1;
			#6 sck = 1'b0;
			#3;
			oe = oe | so_oe;
			if (k >= 15 && k < 31) rx[k-15] = so_out;
		end
		#20;
		cs = 1'b1;
		serial_in = ~serial_in;
		#40;
	endtask
endmodule // sepc_host

// ---- test_sepc_serial_eeprom.sv ----
// bench of the serial eeprom command port
// assumes sepc_pkg and sepc_host are compiled before it
`timescale 1ns/10ps
`include "sepc_regs.svh"
module test_sepc_serial_eeprom;
	localparam int WUS = 2;
	localparam int WCYC = (WUS * 1000 + 9) / 10;
	logic        core_clk;
	logic        resetn;
	logic        reset_pin;
	logic        power_ok;
	logic        sck;
	logic        cs;
	logic        serial_in;
	logic        so_out;
	logic        so_oe;
	logic        rdy_busy;
	logic [15:0] rx;
	logic        oe;
	logic        f;
	int          err_count;
	int          total_checks;
	int          cyc;
	int          low_run;
	int          last_low;

	sepc_serial_eeprom #(.WRITE_TIME_US(WUS)) u_dut (.core_clk(core_clk), .resetn(resetn), .sck(sck),
		.cs(cs), .serial_in(serial_in), .reset_pin(reset_pin), .power_ok(power_ok), .so_out(so_out),
		.so_oe(so_oe), .rdy_busy(rdy_busy));
	sepc_host u_host (.sck(sck), .cs(cs), .serial_in(serial_in), .so_out(so_out), .so_oe(so_oe));

	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	// busy run length and hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (rdy_busy === 1'b0) begin
			low_run <= low_run + 1;
		end else if (low_run != 0) begin
			last_low <= low_run;
			low_run <= 0;
		end
		if (cyc == 60000) begin
			err_count++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk_bit(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (rdy_busy !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
	endtask

	// flag sampled at the sixteenth falling edge
	task automatic stat(input logic [7:0] sel, output logic fl);
		u_host.frame(`SEPC_MODE_STAT, sel, 16'h0, 24, rx, oe);
		fl = rx[0];
	endtask

	task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
		u_host.frame(`SEPC_MODE_READ, {1'b0, a}, 16'h0, 32, rx, oe);
		chk_word("read_data", e, rx);
		chk_bit("so_oe_idle", 1'b0, so_oe);
	endtask

	task automatic idle_ready(input string nm);
		repeat (10) @(posedge core_clk);
		chk_bit(nm, 1'b1, rdy_busy);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_after_reset();
		wait_ready();
		chk_bit("rdy_after_reset", 1'b1, rdy_busy);
		stat(8'h01, f);
		chk_bit("wen_flag_reset", 1'b1, f);
		stat(8'h00, f);
		chk_bit("busy_flag_idle", 1'b1, f);
		chk_bit("so_oe_after_stat", 1'b0, so_oe);
	endtask

	task automatic t_unknown();
		logic [7:0] codes [3];
		codes = '{8'hff, 8'ha1, 8'h00};
		foreach (codes[i]) begin
			u_host.frame(codes[i], 8'h00, 16'hffff, 32, rx, oe);
			chk_bit("unknown_oe", 1'b0, oe);
		end
	endtask

	task automatic t_write(input logic [6:0] a, input logic [15:0] d);
		u_host.frame(`SEPC_MODE_WEN, 8'h5a, 16'h0, 16, rx, oe);
		stat(8'h01, f);
		chk_bit("wen_flag_set", 1'b0, f);
		last_low = 0;
		u_host.frame(`SEPC_MODE_WRITE, {1'b0, a}, d, 32, rx, oe);
		chk_bit("rdy_during_write", 1'b0, rdy_busy);
		stat(8'h00, f);
		chk_bit("busy_flag_write", 1'b0, f);
		wait_ready();
		repeat (2) @(posedge core_clk);
		chk_word("busy_cycles", 16'(WCYC), last_low[15:0]);
		rd_chk(a, d);
		stat(8'h02, f);
		chk_bit("ecc_flag", 1'b0, f);
	endtask

	task automatic t_disable();
		u_host.frame(`SEPC_MODE_WDS, 8'hff, 16'h0, 16, rx, oe);
		stat(8'h01, f);
		chk_bit("wen_flag_clear", 1'b1, f);
		u_host.frame(`SEPC_MODE_WRITE, 8'h7f, 16'hdead, 32, rx, oe);
		idle_ready("rdy_write_disabled");
		rd_chk(7'h7f, 16'h0ff1);
	endtask

	task automatic t_short();
		u_host.frame(`SEPC_MODE_WEN, 8'h00, 16'h0, 16, rx, oe);
		u_host.frame(`SEPC_MODE_WRITE, 8'h2a, 16'h1111, 20, rx, oe);
		idle_ready("rdy_short_frame");
		rd_chk(7'h2a, 16'h8001);
	endtask

	task automatic t_reset_abort();
		u_host.frame(`SEPC_MODE_WRITE, 8'h2a, 16'h7777, 32, rx, oe);
		chk_bit("rdy_before_abort", 1'b0, rdy_busy);
		@(posedge core_clk);
		reset_pin <= 1'b1;
		u_host.frame(`SEPC_MODE_READ, 8'h2a, 16'h0, 32, rx, oe);
		chk_bit("oe_in_reset", 1'b0, oe);
		@(posedge core_clk);
		reset_pin <= 1'b0;
		idle_ready("rdy_after_abort");
		rd_chk(7'h2a, 16'h8001);
	endtask

	task automatic t_power();
		@(posedge core_clk);
		// reset pin high across the power change
		reset_pin <= 1'b1;
		@(posedge core_clk);
		power_ok <= 1'b0;
		repeat (5) @(posedge core_clk);
		chk_bit("rdy_power_low", 1'b0, rdy_busy);
		u_host.frame(`SEPC_MODE_WDS, 8'h00, 16'h0, 16, rx, oe);
		@(posedge core_clk);
		power_ok <= 1'b1;
		@(posedge core_clk);
		reset_pin <= 1'b0;
		wait_ready();
		stat(8'h01, f);
		chk_bit("wen_kept", 1'b0, f);
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		resetn = 1'b0;
		reset_pin = 1'b0;
		power_ok = 1'b1;
		err_count = 0;
		total_checks = 0;
		cyc = 0;
		low_run = 0;
		last_low = 0;
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		t_after_reset();
		t_unknown();
		u_host.frame(`SEPC_MODE_WRITE, 8'h05, 16'h1234, 32, rx, oe);
		idle_ready("rdy_write_never_enabled");
		t_write(7'h00, 16'ha5c3);
		t_write(7'h7f, 16'h0ff1);
		t_write(7'h2a, 16'h8001);
		t_disable();
		t_short();
		t_reset_abort();
		t_power();
		wrap_up();
	end
endmodule // test_sepc_serial_eeprom
